// file: logic/sirpc_pulse_codec.sv
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "sirpc_params.svh"


module sirpc_pulse_codec
  import sirpc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // UART side
  input  wire logic        tx_data_in,
  output logic             decoded_rx_out,
  // Optical transceiver side
  output logic             optical_tx_pulse,
  input  wire logic        optical_rx_in_n,
  // Clocking and reset pins
  input  wire logic        oversample_clock,
  input  wire logic        block_reset_n,
  output logic             osc_powerdown
);
  import sirpc_pkg::*;

  // ========================================================================
  // Declarations
  sirpc_state_t st;
  sirpc_state_t next_st;
  logic         div_tick;
  logic         ext_tick;
  logic         tick;
  logic         osc_down;
  logic         bus_wr;
  logic         hit_ctrl;
  logic         hit_stat;
  logic         tx_fall;
  logic         rx_fall;
  logic         mod_out;
  logic         mod_rise;
  logic [31:0]  ctrl_word;
  logic [31:0]  stat_word;
  logic         enc_busy;
  logic         dec_busy;

  // ========================================================================
  // Oscillator control
  // The crystal is modelled by pclk; powering it down stops the divider
  assign osc_down = st.clock_source_select | st.osc_powerdown_in;
  assign osc_powerdown = osc_down;

  sirpc_divider u_divider (
    .pclk      (pclk),
    .presetn   (presetn),
    .rate_code (st.rate_code),
    .osc_run   (~osc_down),
    .tick      (div_tick)
  );

  // ========================================================================
  // Tick selection
  // The external clock is sampled by pclk, so it must stay well below it
  assign ext_tick = oversample_clock & ~st.ovs_last;
  assign tick     = st.clock_source_select ? ext_tick
                                           : div_tick;

  // ========================================================================
  // Busy flags
  // Software polls these before a rate change; changing the divisor in
  // the middle of a bit would stretch or shrink the pulse in flight
  assign enc_busy = (st.enc_state != SIRPC_ENC_IDLE);
  assign dec_busy = (st.dec_state != SIRPC_DEC_IDLE);

  // ========================================================================
  // Edge detection on the serial lines
  // Transmit data is looked at on ticks only, so a glitch that falls between
  // two ticks is never taken for a space; the receive line is looked at every
  // clock because the incoming pulse may be far shorter than a tick
  assign tx_fall  = st.txd_last & ~tx_data_in;
  assign rx_fall  = st.rxn_last & ~optical_rx_in_n;
  assign mod_out  = (st.enc_state == SIRPC_ENC_PULSE);
  assign mod_rise = mod_out & ~st.mod_last;

  // ========================================================================
  // APB decode
  // Zero wait states; unmapped addresses answer with an error
  // Writes to status are dropped quietly, as it holds only live flags
  // Read data is a plain mux of flops, so it settles in the setup cycle
  assign hit_ctrl = (paddr == `SIRPC_CTRL_OFS);
  assign hit_stat = (paddr == `SIRPC_STATUS_OFS);
  assign bus_wr   = psel & penable & pwrite & hit_ctrl;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~(hit_ctrl | hit_stat);

  always_comb
  begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`SIRPC_CTRL_RATE_MSB:`SIRPC_CTRL_RATE_LSB] = st.rate_code;
    ctrl_word[`SIRPC_CTRL_CLOCK_SOURCE_SELECT_BIT] = st.clock_source_select;
    ctrl_word[`SIRPC_CTRL_PDN_BIT]    = st.osc_powerdown_in;
    ctrl_word[`SIRPC_CTRL_FIXED_BIT]  = st.fixed_pulse_select;
    stat_word = 32'h0000_0000;
    stat_word[`SIRPC_STAT_OSCDN_BIT]  = osc_down;
    stat_word[`SIRPC_STAT_TXBUSY_BIT] = enc_busy;
    stat_word[`SIRPC_STAT_RXBUSY_BIT] = dec_busy;
    stat_word[`SIRPC_STAT_TXOUT_BIT]  = st.tx_out;
    stat_word[`SIRPC_STAT_RXOUT_BIT]  = st.rx_out;
  end

  always_comb
  begin
    if (psel && !pwrite && hit_ctrl)
    begin
      prdata = ctrl_word;
    end
    else if (psel && !pwrite && hit_stat)
    begin
      prdata = stat_word;
    end
    else
    begin
      prdata = 32'h0000_0000;
    end
  end

  // ========================================================================
  // Next state
  always_comb
  begin
    next_st = st;

    // Control register
    if (bus_wr)
    begin
      next_st.rate_code =
        pwdata[`SIRPC_CTRL_RATE_MSB:`SIRPC_CTRL_RATE_LSB];
      next_st.clock_source_select = pwdata[`SIRPC_CTRL_CLOCK_SOURCE_SELECT_BIT];
      next_st.osc_powerdown_in    = pwdata[`SIRPC_CTRL_PDN_BIT];
      next_st.fixed_pulse_select  = pwdata[`SIRPC_CTRL_FIXED_BIT];
    end

    // Line history
    next_st.ovs_last = oversample_clock;
    next_st.rxn_last = optical_rx_in_n;
    next_st.mod_last = mod_out;
    if (tick)
    begin
      next_st.txd_last = tx_data_in;
    end

    // ----------------------------------------------------------------------
    // Encoder, advanced once per tick
    // The count runs over the whole bit; the next zero is looked at only
    // once the bit is over, which keeps pulses exactly one bit apart.
    // Falling edges while busy are ignored, since the UART is bit aligned.
    if (tick)
    begin
      case (st.enc_state)
        SIRPC_ENC_IDLE:
        begin
          if (tx_fall)
          begin
            next_st.enc_state = SIRPC_ENC_WAIT;
            next_st.enc_cnt   = 4'h0;
          end
        end
        SIRPC_ENC_WAIT:
        begin
          next_st.enc_cnt = 4'(st.enc_cnt + 4'h1);
          if (4'(st.enc_cnt + 4'h1) == `SIRPC_ENC_DELAY)
          begin
            next_st.enc_state = SIRPC_ENC_PULSE;
          end
        end
        SIRPC_ENC_PULSE:
        begin
          next_st.enc_cnt = 4'(st.enc_cnt + 4'h1);
          if (4'(st.enc_cnt + 4'h1) ==
              4'(`SIRPC_ENC_DELAY + `SIRPC_ENC_HIGH))
          begin
            next_st.enc_state = SIRPC_ENC_TAIL;
          end
        end
        SIRPC_ENC_TAIL:
        begin
          next_st.enc_cnt = 4'(st.enc_cnt + 4'h1);
          if (st.enc_cnt == `SIRPC_ENC_LAST)
          begin
            // A further zero bit starts the next pulse one bit later
            if (!tx_data_in)
            begin
              next_st.enc_state = SIRPC_ENC_WAIT;
              next_st.enc_cnt   = 4'h0;
            end
            else
            begin
              next_st.enc_state = SIRPC_ENC_IDLE;
              next_st.enc_cnt   = 4'h0;
            end
          end
        end
        default:
        begin
          next_st.enc_state = SIRPC_ENC_IDLE;
          next_st.enc_cnt   = 4'h0;
        end
      endcase
    end

    // ----------------------------------------------------------------------
    // Monoshot, counted in crystal cycles and blind to the rate code
    // With the external clock chosen the monoshot still counts clock
    // cycles; that pairing is not supported and is not policed here
    if (mod_rise)
    begin
      next_st.mono_cnt = `SIRPC_FIXED_CYCLES;
    end
    else if (st.mono_cnt != 3'h0)
    begin
      next_st.mono_cnt = 3'(st.mono_cnt - 3'h1);
    end

    // ----------------------------------------------------------------------
    // Decoder
    // The first stretch is 15 to 16 ticks long because the incoming edge
    // is not tick aligned; that still clears the three-quarter minimum
    case (st.dec_state)
      SIRPC_DEC_IDLE:
      begin
        if (rx_fall)
        begin
          next_st.dec_state = SIRPC_DEC_STRETCH;
          next_st.dec_cnt   = 5'h00;
        end
      end
      SIRPC_DEC_STRETCH:
      begin
        if (rx_fall)
        begin
          next_st.dec_cnt = 5'h00;
        end
        else if (tick)
        begin
          next_st.dec_cnt = 5'(st.dec_cnt + 5'h01);
          // Full bit exceeds the three-quarter minimum with margin
          if (5'(st.dec_cnt + 5'h01) == `SIRPC_BIT_TICKS)
          begin
            next_st.dec_state = SIRPC_DEC_IDLE;
            next_st.dec_cnt   = 5'h00;
          end
        end
      end
      default:
      begin
        next_st.dec_state = SIRPC_DEC_IDLE;
        next_st.dec_cnt   = 5'h00;
      end
    endcase

    // ----------------------------------------------------------------------
    // Block reset pin holds both machines in their initial states
    // Control bits are kept, so software need not reprogram the rate
    if (!block_reset_n)
    begin
      next_st.enc_state = SIRPC_ENC_IDLE;
      next_st.enc_cnt   = 4'h0;
      next_st.dec_state = SIRPC_DEC_IDLE;
      next_st.dec_cnt   = 5'h00;
      next_st.mono_cnt  = 3'h0;
    end

    // ----------------------------------------------------------------------
    // Output flops
    // Both pins come straight from flops so they cannot glitch while the
    // state machines change state
    if (st.fixed_pulse_select)
    begin
      next_st.tx_out = (next_st.mono_cnt != 3'h0);
    end
    else
    begin
      next_st.tx_out = (next_st.enc_state == SIRPC_ENC_PULSE);
    end
    next_st.rx_out = (next_st.dec_state == SIRPC_DEC_IDLE);
    if (!block_reset_n)
    begin
      next_st.tx_out = 1'b0;
      next_st.rx_out = 1'b1;
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st                     <= '0;
      st.rate_code           <= 3'h0;
      st.clock_source_select <= 1'b0;
      st.osc_powerdown_in    <= 1'b0;
      st.fixed_pulse_select  <= 1'b0;
      st.ovs_last            <= 1'b0;
      st.txd_last            <= 1'b1;
      st.rxn_last            <= 1'b1;
      st.enc_state           <= SIRPC_ENC_IDLE;
      st.dec_state           <= SIRPC_DEC_IDLE;
      st.tx_out              <= 1'b0;
      st.rx_out              <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ========================================================================
  // Outputs
  // Reset drives the emitter off and the UART line to mark, so the far
  // side sees an idle link until the first bit is sent
  assign optical_tx_pulse = st.tx_out;
  assign decoded_rx_out   = st.rx_out;

endmodule : sirpc_pulse_codec

// file: pkg/sirpc_params.svh
`ifndef SIRPC_PARAMS_SVH
`define SIRPC_PARAMS_SVH

// ==========================================================================
// Register map (byte addresses, one 32-bit word each)
`define SIRPC_CTRL_OFS        12'h000
`define SIRPC_STATUS_OFS      12'h004

// ==========================================================================
// Control register fields
`define SIRPC_CTRL_RATE_LSB   0
`define SIRPC_CTRL_RATE_MSB   2
`define SIRPC_CTRL_CLOCK_SOURCE_SELECT_BIT 3
`define SIRPC_CTRL_PDN_BIT    4
`define SIRPC_CTRL_FIXED_BIT  5
`define SIRPC_CTRL_RESET      6'h00

// ==========================================================================
// Status register fields
`define SIRPC_STAT_OSCDN_BIT  0
`define SIRPC_STAT_TXBUSY_BIT 1
`define SIRPC_STAT_RXBUSY_BIT 2
`define SIRPC_STAT_TXOUT_BIT  3
`define SIRPC_STAT_RXOUT_BIT  4

// ==========================================================================
// Crystal divisors per rate code
`define SIRPC_DIV_000         7'h02
`define SIRPC_DIV_001         7'h04
`define SIRPC_DIV_010         7'h0c
`define SIRPC_DIV_011         7'h18
`define SIRPC_DIV_100         7'h06
`define SIRPC_DIV_101         7'h30
`define SIRPC_DIV_110         7'h60
`define SIRPC_DIV_111         7'h01

// ==========================================================================
// Timing counts in oversampling ticks or crystal cycles
`define SIRPC_ENC_DELAY       4'h7
`define SIRPC_ENC_HIGH        4'h3
`define SIRPC_ENC_LAST        4'hf
`define SIRPC_BIT_TICKS       5'h10
`define SIRPC_RX_MIN_TICKS    5'h0c
`define SIRPC_FIXED_CYCLES    3'h6

`endif

// file: pkg/sirpc_pkg.sv
package sirpc_pkg;

  // ========================================================================
  // Encoder states, Gray along idle-wait-pulse-tail
  typedef enum logic [1:0] {
    SIRPC_ENC_IDLE  = 2'h0,
    SIRPC_ENC_WAIT  = 2'h1,
    SIRPC_ENC_PULSE = 2'h3,
    SIRPC_ENC_TAIL  = 2'h2
  } sirpc_enc_state_t;

  // ========================================================================
  // Decoder states
  typedef enum logic {
    SIRPC_DEC_IDLE    = 1'h0,
    SIRPC_DEC_STRETCH = 1'h1
  } sirpc_dec_state_t;

  // ========================================================================
  // Divider state
  typedef struct packed {
    logic [6:0] cnt;
  } sirpc_div_t;

  // ========================================================================
  // Codec state
  typedef struct packed {
    logic [2:0]       rate_code;
    logic             clock_source_select;
    logic             osc_powerdown_in;
    logic             fixed_pulse_select;
    logic             ovs_last;
    logic             txd_last;
    logic             rxn_last;
    sirpc_enc_state_t enc_state;
    logic [3:0]       enc_cnt;
    logic             mod_last;
    logic [2:0]       mono_cnt;
    logic             tx_out;
    sirpc_dec_state_t dec_state;
    logic [4:0]       dec_cnt;
    logic             rx_out;
  } sirpc_state_t;

endpackage : sirpc_pkg

// file: logic/sirpc_divider.sv
`timescale 1ns/10ps
`include "sirpc_params.svh"

module sirpc_divider
  import sirpc_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic [2:0] rate_code,
  input  wire logic       osc_run,
  // Sixteen-times tick
  output logic            tick
);
  import sirpc_pkg::*;

  sirpc_div_t   st;
  sirpc_div_t   next_st;
  logic [6:0]   divisor;

  // ========================================================================
  // Divisor lookup
  always_comb
  begin
    case (rate_code)
      3'h0:    divisor = `SIRPC_DIV_000;
      3'h1:    divisor = `SIRPC_DIV_001;
      3'h2:    divisor = `SIRPC_DIV_010;
      3'h3:    divisor = `SIRPC_DIV_011;
      3'h4:    divisor = `SIRPC_DIV_100;
      3'h5:    divisor = `SIRPC_DIV_101;
      3'h6:    divisor = `SIRPC_DIV_110;
      default: divisor = `SIRPC_DIV_111;
    endcase
  end

  // ========================================================================
  // Counter; a stopped oscillator yields no ticks
  // The compare uses >= so a code change to a smaller divisor cannot stall
  always_comb
  begin
    next_st = st;
    tick    = 1'b0;
    if (!osc_run)
    begin
      next_st.cnt = 7'h00;
    end
    else if (st.cnt >= 7'(divisor - 7'h01))
    begin
      next_st.cnt = 7'h00;
      tick        = 1'b1;
    end
    else
    begin
      next_st.cnt = 7'(st.cnt + 7'h01);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule : sirpc_divider

// file: tb/sirpc_pulse_codec_props.sv
`timescale 1ns/10ps
// ========
// Port checker
module sirpc_pulse_codec_props
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Pins
  input wire logic        tx_data_in,
  input wire logic        decoded_rx_out,
  input wire logic        optical_tx_pulse,
  input wire logic        optical_rx_in_n,
  input wire logic        block_reset_n,
  input wire logic        osc_powerdown
);
  localparam int DIV [8] = '{2, 4, 12, 24, 6, 48, 96, 1};
  logic [5:0]  ctrl;
  logic [11:0] hi;
  logic [11:0] lo;
  logic [11:0] idl;
  int          n;

  // Shadow control word, so expected widths follow the rate code
  assign n = DIV[ctrl[2:0]];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= 6'h00;
      hi   <= 12'h000;
      lo   <= 12'h000;
      idl  <= 12'h000;
    end
    else
    begin
      if (psel && penable && pwrite && paddr == 12'h000)
        ctrl <= pwdata[5:0];
      hi  <= optical_tx_pulse ? hi + 12'h001 : 12'h000;
      lo  <= decoded_rx_out ? 12'h000 : lo + 12'h001;
      idl <= (!tx_data_in || psel) ? 12'h000 : idl + {11'h000, idl != 12'hfff};
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_osc_pdn: assert property (
    osc_powerdown == (ctrl[3] | ctrl[4]))
    else $error("oscillator powerdown wrong");
  a_tx_width: assert property (
    $fell(optical_tx_pulse) && $past(block_reset_n) && ctrl[5:3] == 3'h0
    |-> hi == 3 * n)
    else $error("encoded pulse width wrong");
  a_mono_width: assert property (
    $fell(optical_tx_pulse) && $past(block_reset_n) && ctrl[5] && !ctrl[3]
    |-> hi == 12'h006)
    else $error("fixed pulse width wrong");
  a_rx_answer: assert property (
    $fell(optical_rx_in_n) && block_reset_n |=> !decoded_rx_out)
    else $error("received pulse not decoded");
  a_rx_min_low: assert property (
    $rose(decoded_rx_out) && $past(block_reset_n) |-> lo >= 12'h00c)
    else $error("stretch too short");
  a_rx_bit_len: assert property (
    $rose(decoded_rx_out) && $past(block_reset_n) && ctrl[4:3] == 2'h0
    |-> lo >= 15 * n)
    else $error("stretch below one bit");
  a_tx_mark: assert property (
    idl > 12'h44c && !ctrl[3] |-> !optical_tx_pulse)
    else $error("pulse during mark");
  a_reset_out: assert property (
    !block_reset_n |=> !optical_tx_pulse && decoded_rx_out)
    else $error("block reset outputs wrong");

  c_pulse: cover property ($rose(optical_tx_pulse) && ctrl[5:3] == 3'h0);
  c_mono: cover property ($fell(optical_tx_pulse) && ctrl[5]);
  c_restart: cover property (!decoded_rx_out && $fell(optical_rx_in_n));
endmodule : sirpc_pulse_codec_props

bind sirpc_pulse_codec sirpc_pulse_codec_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .tx_data_in(tx_data_in), .decoded_rx_out(decoded_rx_out),
  .optical_tx_pulse(optical_tx_pulse), .optical_rx_in_n(optical_rx_in_n),
  .block_reset_n(block_reset_n), .osc_powerdown(osc_powerdown));

// file: tb/sirpc_far_model.sv
`timescale 1ns/10ps
// ========
// UART and optical transceiver model
module sirpc_far_model
(
  // Clock
  input  wire logic pclk,
  // Driven lines
  output logic      tx_data_in = 1'h1,
  output logic      optical_rx_in_n = 1'h1,
  output logic      oversample_clock = 1'h0,
  // Watched lines
  input  wire logic optical_tx_pulse,
  input  wire logic decoded_rx_out
);
  int cyc = 0;
  int fall_cyc = 0;
  int ext_period = 0;
  int hi = 0;
  int lo = 0;
  int width = 0;
  int lo_len = 0;
  int lo_runs = 0;
  int rise_q[$];

  // External tick stands low while the period is zero
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    oversample_clock <= ext_period > 0 && cyc % ext_period == 0;
    if (optical_tx_pulse === 1'h1 && hi == 0)
      rise_q.push_back(cyc);
    hi <= optical_tx_pulse === 1'h1 ? hi + 1 : 0;
    if (optical_tx_pulse !== 1'h1 && hi > 0)
      width <= hi;
    lo <= decoded_rx_out === 1'h0 ? lo + 1 : 0;
    if (decoded_rx_out !== 1'h0 && lo > 0)
    begin
      lo_len <= lo;
      lo_runs <= lo_runs + 1;
    end
  end

  task automatic send(input logic [7:0] bits, input int nb, input int bt);
    for (int i = 0; i < nb; i++)
    begin
      @(posedge pclk);
      if (!bits[i] && tx_data_in)
        fall_cyc = cyc;
      tx_data_in <= bits[i];
      repeat (bt - 1) @(posedge pclk);
    end
    @(posedge pclk);
    tx_data_in <= 1'h1;
  endtask : send

  task automatic ir(input int w);
    @(posedge pclk);
    optical_rx_in_n <= 1'h0;
    repeat (w) @(posedge pclk);
    optical_rx_in_n <= 1'h1;
  endtask : ir
endmodule : sirpc_far_model

// file: tb/sir_pulse_codec_tb_top.sv
`timescale 1ns/10ps
// ========
// Bench top
module sir_pulse_codec_tb_top;
  localparam int DIV [8] = '{2, 4, 12, 24, 6, 48, 96, 1};
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        err;
  logic        pslverr;
  logic        tx_data_in;
  logic        decoded_rx_out;
  logic        optical_tx_pulse;
  logic        optical_rx_in_n;
  logic        oversample_clock;
  logic        block_reset_n = 1'h1;
  logic        osc_powerdown;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          d;

  sirpc_pulse_codec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_data_in(tx_data_in), .decoded_rx_out(decoded_rx_out),
    .optical_tx_pulse(optical_tx_pulse), .optical_rx_in_n(optical_rx_in_n),
    .oversample_clock(oversample_clock), .block_reset_n(block_reset_n),
    .osc_powerdown(osc_powerdown));
  sirpc_far_model u_far (.pclk(pclk), .tx_data_in(tx_data_in),
    .optical_rx_in_n(optical_rx_in_n), .oversample_clock(oversample_clock),
    .optical_tx_pulse(optical_tx_pulse), .decoded_rx_out(decoded_rx_out));

  always #25 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // One zero bit, then long idle so the encoder settles before the next case
  task automatic tx_case(input logic [5:0] c, input int n, cnt, w);
    apb(1'h1, 12'h000, {26'h0, c});
    u_far.rise_q.delete();
    u_far.send(8'h00, 1, 16 * n);
    repeat (16 * n) @(posedge pclk);
    chk("pulse count", cnt, u_far.rise_q.size());
    if (cnt > 0)
    begin
      d = u_far.rise_q[0] - u_far.fall_cyc;
      chk("pulse width", w, u_far.width);
      chk("pulse delay", 1'h1, d > 7 * n && d <= 8 * n + 4);
    end
  endtask : tx_case

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    chk("tx idle", 1'h0, optical_tx_pulse);
    chk("rx idle", 1'h1, decoded_rx_out);
    apb(1'h0, 12'h004, 32'h0);
    chk("status", 32'h10, rd);
    apb(1'h1, 12'h008, 32'hff);
    chk("unmapped", 1'h1, err);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'h1, 12'h000, i << 3);
      apb(1'h0, 12'h004, 32'h0);
      chk("osc pin", i != 0, osc_powerdown);
      chk("osc flag", i != 0, rd[0]);
    end
    apb(1'h0, 12'h000, 32'h0);
    chk("ctrl", 32'h18, rd);
    $display("test registers done");
    for (int c = 0; c < 8; c++)
      tx_case(c[5:0], DIV[c], 1, 3 * DIV[c]);
    apb(1'h1, 12'h000, 32'h0);
    u_far.rise_q.delete();
    u_far.send(8'h04, 4, 32);
    repeat (64) @(posedge pclk);
    chk("train", 3, u_far.rise_q.size());
    chk("gap", 32, u_far.rise_q[1] - u_far.rise_q[0]);
    chk("gap one", 64, u_far.rise_q[2] - u_far.rise_q[1]);
    tx_case(6'h25, 48, 1, 6);
    tx_case(6'h20, 2, 1, 6);
    $display("test encoder done");
    tx_case(6'h08, 4, 0, 0);
    chk("osc ext", 1'h1, osc_powerdown);
    u_far.ext_period = 4;
    tx_case(6'h08, 4, 1, 12);
    $display("test external clock done");
    apb(1'h1, 12'h000, 32'h0);
    u_far.ir(3);
    apb(1'h0, 12'h004, 32'h0);
    chk("status stretch", 32'h04, rd);
    apb(1'h0, 12'h00c, 32'h0);
    chk("read error", 1'h1, err);
    chk("read zero", 32'h0, rd);
    repeat (34) @(posedge pclk);
    d = u_far.lo_len;
    chk("stretch", 1'h1, d >= 30 && d <= 34);
    d = u_far.lo_runs;
    u_far.ir(3);
    repeat (16) @(posedge pclk);
    u_far.ir(3);
    repeat (40) @(posedge pclk);
    chk("runs", d + 1, u_far.lo_runs);
    chk("restart", 1'h1, u_far.lo_len >= 48);
    u_far.ir(3);
    repeat (4) @(posedge pclk);
    block_reset_n <= 1'h0;
    repeat (2) @(posedge pclk);
    chk("rx reset", 1'h1, decoded_rx_out);
    chk("tx reset", 1'h0, optical_tx_pulse);
    block_reset_n <= 1'h1;
    $display("test decoder done");
    conclude();
  end
endmodule : sir_pulse_codec_tb_top
